// *** gpodp_top.v ***
// APB register block for GPIO output levels, direction and pull-downs of a 17-pin port.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "gpodp_defs.vh"

module gpodp_top (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [31:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output wire pready_o,
    output wire [31:0] prdata_o,
    output wire pslverr_o,
    // Pad controls, bit 16 is pin 16
    output wire [16:0] pin_level_o,
    output wire [16:0] pin_output_enable_o,
    output wire [16:0] pin_pulldown_o
);

    reg [15:0] level_low_r;
    reg [15:0] level_low_nxt;
    reg level_high_r;
    reg level_high_nxt;
    reg [15:0] dir_low_r;
    reg [15:0] dir_low_nxt;
    reg dir_high_r;
    reg dir_high_nxt;
    reg [15:0] pd_low_r;
    reg [15:0] pd_low_nxt;
    reg pd_high_r;
    reg pd_high_nxt;
    reg [31:0] rdata_r;
    reg [31:0] rdata_nxt;
    reg err_r;
    reg err_nxt;

    wire [15:0] idx;
    wire addr_ok;
    wire setup;
    wire wr;
    wire [15:0] wmask;
    wire [15:0] wdat;
    wire hbit;
    reg mapped;
    reg [15:0] rd_val;

    assign idx = paddr_i[17:2];
    // Word alignment and zero upper address bits keep aliases off the map.
    assign addr_ok = (paddr_i[1:0] == 2'b00) && (paddr_i[31:18] == 14'h0000);
    assign setup = psel_i && !penable_i;
    assign wr = psel_i && penable_i && pwrite_i && !err_r;
    // Byte strobes gate the two low lanes; upper lanes hold nothing.
    assign wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    assign wdat = pwdata_i[15:0] & wmask;
    assign hbit = wdat[`GPODP_HIGH_BIT];

    // Read decode; alias registers return zero because they store nothing.
    always @* begin
        mapped = 1'b1;
        rd_val = 16'h0000;
        case (idx)
            `GPODP_IDX_OUTPUT_LEVEL_HIGH: begin
                rd_val = {15'h0000, level_high_r};
            end
            `GPODP_IDX_OUTPUT_LEVEL_LOW: begin
                rd_val = level_low_r;
            end
            `GPODP_IDX_DIRECTION_HIGH: begin
                rd_val = {15'h0000, dir_high_r};
            end
            `GPODP_IDX_DIRECTION_LOW: begin
                rd_val = dir_low_r;
            end
            `GPODP_IDX_PULLDOWN_HIGH: begin
                rd_val = {15'h0000, pd_high_r};
            end
            `GPODP_IDX_PULLDOWN_LOW: begin
                rd_val = pd_low_r;
            end
            `GPODP_IDX_OUTPUT_SET_HIGH,
            `GPODP_IDX_OUTPUT_SET_LOW,
            `GPODP_IDX_OUTPUT_CLEAR_HIGH,
            `GPODP_IDX_OUTPUT_CLEAR_LOW,
            `GPODP_IDX_DIRECTION_SET_HIGH,
            `GPODP_IDX_DIRECTION_SET_LOW,
            `GPODP_IDX_DIRECTION_CLEAR_HIGH,
            `GPODP_IDX_DIRECTION_CLEAR_LOW: begin
                rd_val = 16'h0000;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Read data and the error flag are captured in the setup cycle so that
    // the access phase can complete at once with both coming from flip-flops.
    always @* begin
        rdata_nxt = rdata_r;
        err_nxt = err_r;
        if (setup) begin
            err_nxt = !(addr_ok && mapped);
            rdata_nxt = (addr_ok && mapped && !pwrite_i) ? {16'h0000, rd_val} : 32'h00000000;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= 32'h00000000;
            err_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
        end
    end

    // Each stored register has its own update; only bits written as one reach the
    // set and clear targets, so the zero bits of an alias write change nothing.
    always @* begin
        level_low_nxt = level_low_r;
        if (wr) begin
            case (idx)
                `GPODP_IDX_OUTPUT_LEVEL_LOW: begin
                    level_low_nxt = (level_low_r & ~wmask) | wdat;
                end
                `GPODP_IDX_OUTPUT_SET_LOW: begin
                    level_low_nxt = level_low_r | wdat;
                end
                `GPODP_IDX_OUTPUT_CLEAR_LOW: begin
                    level_low_nxt = level_low_r & ~wdat;
                end
                default: begin
                    level_low_nxt = level_low_r;
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            level_low_r <= `GPODP_RST_LEVEL_LOW;
        end else begin
            level_low_r <= level_low_nxt;
        end
    end

    always @* begin
        level_high_nxt = level_high_r;
        if (wr) begin
            case (idx)
                `GPODP_IDX_OUTPUT_LEVEL_HIGH: begin
                    if (pstrb_i[0]) begin
                        level_high_nxt = pwdata_i[`GPODP_HIGH_BIT];
                    end
                end
                `GPODP_IDX_OUTPUT_SET_HIGH: begin
                    level_high_nxt = level_high_r | hbit;
                end
                `GPODP_IDX_OUTPUT_CLEAR_HIGH: begin
                    level_high_nxt = level_high_r & ~hbit;
                end
                default: begin
                    level_high_nxt = level_high_r;
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            level_high_r <= `GPODP_RST_LEVEL_HIGH;
        end else begin
            level_high_r <= level_high_nxt;
        end
    end

    always @* begin
        dir_low_nxt = dir_low_r;
        if (wr) begin
            case (idx)
                `GPODP_IDX_DIRECTION_LOW: begin
                    dir_low_nxt = (dir_low_r & ~wmask) | wdat;
                end
                `GPODP_IDX_DIRECTION_SET_LOW: begin
                    dir_low_nxt = dir_low_r | wdat;
                end
                `GPODP_IDX_DIRECTION_CLEAR_LOW: begin
                    dir_low_nxt = dir_low_r & ~wdat;
                end
                default: begin
                    dir_low_nxt = dir_low_r;
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            dir_low_r <= `GPODP_RST_DIR_LOW;
        end else begin
            dir_low_r <= dir_low_nxt;
        end
    end

    always @* begin
        dir_high_nxt = dir_high_r;
        if (wr) begin
            case (idx)
                `GPODP_IDX_DIRECTION_HIGH: begin
                    if (pstrb_i[0]) begin
                        dir_high_nxt = pwdata_i[`GPODP_HIGH_BIT];
                    end
                end
                `GPODP_IDX_DIRECTION_SET_HIGH: begin
                    dir_high_nxt = dir_high_r | hbit;
                end
                `GPODP_IDX_DIRECTION_CLEAR_HIGH: begin
                    dir_high_nxt = dir_high_r & ~hbit;
                end
                default: begin
                    dir_high_nxt = dir_high_r;
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            dir_high_r <= `GPODP_RST_DIR_HIGH;
        end else begin
            dir_high_r <= dir_high_nxt;
        end
    end

    always @* begin
        pd_low_nxt = pd_low_r;
        if (wr) begin
            case (idx)
                `GPODP_IDX_PULLDOWN_LOW: begin
                    pd_low_nxt = (pd_low_r & ~wmask) | wdat;
                end
                default: begin
                    pd_low_nxt = pd_low_r;
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            pd_low_r <= `GPODP_RST_PD_LOW;
        end else begin
            pd_low_r <= pd_low_nxt;
        end
    end

    always @* begin
        pd_high_nxt = pd_high_r;
        if (wr) begin
            case (idx)
                `GPODP_IDX_PULLDOWN_HIGH: begin
                    if (pstrb_i[0]) begin
                        pd_high_nxt = pwdata_i[`GPODP_HIGH_BIT];
                    end
                end
                default: begin
                    pd_high_nxt = pd_high_r;
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            pd_high_r <= `GPODP_RST_PD_HIGH;
        end else begin
            pd_high_r <= pd_high_nxt;
        end
    end

    // Zero wait states: every access phase completes in its first cycle.
    assign pready_o = 1'b1;
    assign prdata_o = rdata_r;
    assign pslverr_o = psel_i && penable_i && err_r;

    // The pad sees the stored level; with the driver off it may read differently.
    assign pin_level_o = {level_high_r, level_low_r};
    assign pin_output_enable_o = {dir_high_r, dir_low_r};
    assign pin_pulldown_o = {pd_high_r, pd_low_r};

endmodule

// *** gpodp_defs.vh ***
// Register indices, reset values and field layout of the GPIO output, direction and pull-down block.
`ifndef GPODP_DEFS_VH
`define GPODP_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define GPODP_IDX_OUTPUT_LEVEL_HIGH 16'h4704
`define GPODP_IDX_OUTPUT_LEVEL_LOW 16'h4706
`define GPODP_IDX_OUTPUT_SET_HIGH 16'h4708
`define GPODP_IDX_OUTPUT_SET_LOW 16'h470a
`define GPODP_IDX_OUTPUT_CLEAR_HIGH 16'h470c
`define GPODP_IDX_OUTPUT_CLEAR_LOW 16'h470e
`define GPODP_IDX_DIRECTION_HIGH 16'h4714
`define GPODP_IDX_DIRECTION_LOW 16'h4716
`define GPODP_IDX_DIRECTION_SET_HIGH 16'h4718
`define GPODP_IDX_DIRECTION_SET_LOW 16'h471a
`define GPODP_IDX_DIRECTION_CLEAR_HIGH 16'h471c
`define GPODP_IDX_DIRECTION_CLEAR_LOW 16'h471e
`define GPODP_IDX_PULLDOWN_HIGH 16'h4720
`define GPODP_IDX_PULLDOWN_LOW 16'h4722

// Field layout: the high registers hold pin 16 in bit 0.
`define GPODP_HIGH_BIT 0
`define GPODP_LOW_WIDTH 16

// Reset values.
`define GPODP_RST_LEVEL_LOW 16'h0000
`define GPODP_RST_LEVEL_HIGH 1'b0
`define GPODP_RST_DIR_LOW 16'h0000
`define GPODP_RST_DIR_HIGH 1'b0
`define GPODP_RST_PD_LOW 16'h0000
`define GPODP_RST_PD_HIGH 1'b0

`endif

// *** gpodp_chk_sva.sv ***
// Bus-to-pin checker for the GPIO output, direction and pull-down registers.
`timescale 1ns/1ps
module gpodp_chk (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // APB slave side
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [31:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    input wire pready_o,
    input wire [31:0] prdata_o,
    input wire pslverr_o,
    // Pad controls
    input wire [16:0] pin_level_o,
    input wire [16:0] pin_output_enable_o,
    input wire [16:0] pin_pulldown_o
);
    wire [15:0] wd = pwdata_i[15:0];
    wire [15:0] ll = pin_level_o[15:0];
    wire [15:0] ol = pin_output_enable_o[15:0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Only full low-lane writes are tracked, so partial strobes never trip these checks.
    sequence wr(int a);
        psel_i && penable_i && pwrite_i && pstrb_i[1:0] == 2'b11 && paddr_i == a * 4;
    endsequence
    sequence rd(int a);
        psel_i && penable_i && !pwrite_i && paddr_i == a * 4;
    endsequence
    a_set_low: assert property (wr(16'h470a) |=> ll == ($past(ll) | $past(wd)))
        else $error("set low");
    a_clr_low: assert property (wr(16'h470e) |=> ll == ($past(ll) & ~$past(wd)))
        else $error("clear low");
    a_clr_high: assert property (wr(16'h470c) ##0 wd[0] |=> !pin_level_o[16])
        else $error("clear high");
    a_dir_low: assert property (wr(16'h4716) |=> ol == $past(wd))
        else $error("direction low");
    a_dset_low: assert property (wr(16'h471a) |=> ol == ($past(ol) | $past(wd)))
        else $error("direction set low");
    a_dclr_high: assert property (wr(16'h471c) ##0 wd[0] |=> !pin_output_enable_o[16])
        else $error("direction clear high");
    a_pd_low: assert property (wr(16'h4722) |=> pin_pulldown_o[15:0] == $past(wd))
        else $error("pulldown low");
    a_alias_zero: assert property (rd(16'h470c) |-> prdata_o == 32'h0)
        else $error("alias read");
    a_reset_idle: assert property (disable iff (1'b0) !rst_n_i |=>
        pin_output_enable_o == 17'h0 && pin_pulldown_o == 17'h0) else $error("reset");
endmodule
bind gpodp_top gpodp_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .pin_level_o(pin_level_o), .pin_output_enable_o(pin_output_enable_o),
    .pin_pulldown_o(pin_pulldown_o));

// *** gpodp_top_tb.sv ***
// Register-level testbench for the GPIO output, direction and pull-down block.
`timescale 1ns/1ps
module gpodp_top_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [31:0] paddr_i = 32'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0] pstrb_i = 4'hf;
    wire pready_o;
    wire pslverr_o;
    wire [31:0] prdata_o;
    wire [16:0] lv;
    wire [16:0] oe;
    wire [16:0] pd;
    int n_fail = 0;
    int cmp_count = 0;
    always #25 clk_i = ~clk_i;
    gpodp_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .pin_level_o(lv), .pin_output_enable_o(oe), .pin_pulldown_o(pd));
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // One APB transfer; an idle cycle follows so the pins have settled on return.
    task automatic xf(logic w, logic [15:0] i, logic [31:0] d, output logic [31:0] r,
        output logic e);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {14'h0, i, 2'b00};
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic w(logic [15:0] i, logic [31:0] d);
        logic [31:0] r;
        logic e;
        xf(1'b1, i, d, r, e);
        chk("write error", 32'h0, {31'h0, e});
    endtask
    task automatic rd(logic [15:0] i, logic [31:0] x, logic ex = 1'b0);
        logic [31:0] r;
        logic e;
        xf(1'b0, i, 32'h0, r, e);
        chk("read data", x, r);
        chk("read error", {31'h0, ex}, {31'h0, e});
    endtask
    task automatic pins(logic [16:0] l, logic [16:0] o, logic [16:0] p);
        chk("pin level", {15'h0, l}, {15'h0, lv});
        chk("pin enable", {15'h0, o}, {15'h0, oe});
        chk("pin pulldown", {15'h0, p}, {15'h0, pd});
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        pins(17'h0, 17'h0, 17'h0);
        rd(16'h4716, 32'h0);
        rd(16'h4722, 32'h0);
        $display("test reset done");
        w(16'h4706, 32'h00f0);
        w(16'h470a, 32'h0f0f);
        pins(17'h00fff, 17'h0, 17'h0);
        w(16'h470e, 32'h00ff);
        rd(16'h4706, 32'h0f00);
        w(16'h4708, 32'h1);
        w(16'h470c, 32'h0);
        pins(17'h10f00, 17'h0, 17'h0);
        w(16'h470c, 32'hffff);
        pins(17'h00f00, 17'h0, 17'h0);
        rd(16'h470c, 32'h0);
        $display("test level done");
        w(16'h4716, 32'ha5a5);
        rd(16'h4716, 32'ha5a5);
        w(16'h471a, 32'h000f);
        w(16'h471e, 32'h8001);
        pins(17'h00f00, 17'h025ae, 17'h0);
        w(16'h4718, 32'h1);
        rd(16'h4714, 32'h1);
        w(16'h471c, 32'h1);
        rd(16'h4714, 32'h0);
        w(16'h4714, 32'hffff);
        rd(16'h4714, 32'h1);
        $display("test direction done");
        w(16'h4722, 32'h1234);
        w(16'h4720, 32'h1);
        pins(17'h00f00, 17'h125ae, 17'h11234);
        rd(16'h4722, 32'h1234);
        pstrb_i <= 4'h1;
        w(16'h4722, 32'hffff);
        pstrb_i <= 4'hf;
        pins(17'h00f00, 17'h125ae, 17'h112ff);
        w(16'h4704, 32'hffff);
        rd(16'h4704, 32'h1);
        rd(16'h4708, 32'h0);
        rd(16'h4710, 32'h0, 1'b1);
        $display("test pulldown done");
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        pins(17'h0, 17'h0, 17'h0);
        rd(16'h4714, 32'h0);
        rd(16'h4720, 32'h0);
        $display("test second reset done");
        tally_and_finish;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        n_fail++;
        tally_and_finish;
    end
endmodule
